/* File: hdl/tmr8_core.sv */
// The strobed register port and the placing of the registers were decided locally.
`include "tmr8_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tmr8_core
   import tmr8_pkg::*;
#(
   parameter int PRESCALE_W = 10
) (
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       ARST_N,
   // Register port
   input  wire tmr8_req_t  REQ,
   output logic [7:0]      RDATA,
   // Interrupt side
   input  wire logic       GLOBAL_IRQ_EN,
   input  wire tmr8_irq_t  IRQ_ACK,
   output tmr8_irq_t       IRQ_REQ,
   // Pins
   input  wire logic       EXT_COUNT_PIN,
   output logic            WAVE_OUT_A,
   output logic            WAVE_OUT_B,
   output logic            WAVE_EN_A,
   output logic            WAVE_EN_B
);

////////////////////////////////////////////////////////////////////////////////
   logic [7:0]            ctrl_a_reg;
   logic [3:0]            ctrl_b_reg;   // mode high bit and clock select
   logic [7:0]            count_reg;
   logic [7:0]            cmp_a_reg;
   logic [7:0]            cmp_b_reg;
   logic [7:0]            cmp_a_buf_reg;
   logic [7:0]            cmp_b_buf_reg;
   logic [2:0]            mask_reg;
   logic [2:0]            flag_reg;
   logic [2:0]            flag_next;
   logic                  down_reg;
   logic                  block_reg;
   logic                  pin_reg;
   logic [PRESCALE_W-1:0] pre_reg;
   logic                  wave_a_reg;
   logic                  wave_b_reg;
   logic [7:0]            rdata_reg;
   tmr8_wmode_t           wmode;
   logic [7:0]            top;
   logic                  tick;
   logic                  pwm;
   logic                  phase_c;
   logic                  wr_count;
   logic                  at_top;
   logic                  match_a;
   logic                  match_b;
   logic                  ovf_ev;
   logic                  force_a;
   logic                  force_b;
   logic                  upd_pt;

   // Prescaler tap test: true once every 2^n I/O clocks
   function automatic logic tap(input logic [PRESCALE_W-1:0] p, input int div);
      logic [PRESCALE_W-1:0] m;
      m = PRESCALE_W'(div - 1);
      tap = (p & m) == m;
   endfunction

   // Register port write decode
   function automatic logic wr_to(input tmr8_req_t r, input logic [2:0] ofs);
      wr_to = r.wr && (r.addr == ofs);
   endfunction

////////////////////////////////////////////////////////////////////////////////
   // Mode decode
   assign wmode   = tmr8_wmode_t'({ctrl_b_reg[3], ctrl_a_reg[1:0]});
   assign pwm     = wmode[0];        // Odd codes are PWM; reserved codes act non-PWM
   assign phase_c = (wmode == TMR8_WM_PC_FF) || (wmode == TMR8_WM_PC_OCA);
   assign top     = (wmode == TMR8_WM_CTC || wmode == TMR8_WM_PC_OCA ||
                     wmode == TMR8_WM_FAST_OCA) ? cmp_a_reg : `TMR8_MAX;
   assign at_top  = count_reg == top;
   assign wr_count = wr_to(REQ, `TMR8_OFS_COUNT);

   // Clock select picks a count enable; the prescaler runs free
   always_comb begin
      unique case (ctrl_b_reg[2:0])
         3'h0: tick = 1'b0;
         3'h1: tick = 1'b1;
         3'h2: tick = tap(pre_reg, `TMR8_DIV8);
         3'h3: tick = tap(pre_reg, `TMR8_DIV64);
         3'h4: tick = tap(pre_reg, `TMR8_DIV256);
         3'h5: tick = tap(pre_reg, `TMR8_DIV1024);
         3'h6: tick = pin_reg && !EXT_COUNT_PIN;
         3'h7: tick = !pin_reg && EXT_COUNT_PIN;
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_reg + 1'b1;
      end
   end

   // Pin history for edge detection; pin itself is taken as synchronous
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pin_reg <= 1'b0;
      end else begin
         pin_reg <= EXT_COUNT_PIN;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Compare events, suppressed on the tick after a counter write
   assign match_a = tick && !block_reg && (count_reg == cmp_a_reg);
   assign match_b = tick && !block_reg && (count_reg == cmp_b_reg);

   // Overflow point by mode
   always_comb begin
      unique case (wmode)
         TMR8_WM_PC_FF, TMR8_WM_PC_OCA:
            ovf_ev = tick && down_reg && count_reg == 8'h01;  // Reaching BOTTOM
         TMR8_WM_FAST_OCA:
            ovf_ev = tick && at_top;
         default:
            ovf_ev = tick && count_reg == `TMR8_MAX;
      endcase
   end

   // Counter; a software write beats a tick
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         count_reg <= `TMR8_RST_BYTE;
         down_reg  <= 1'b0;
      end else if (wr_count) begin
         count_reg <= REQ.wdata;
      end else if (tick) begin
         if (phase_c) begin
            if (!down_reg && at_top) begin
               down_reg  <= 1'b1;
               count_reg <= count_reg - 1'b1;
            end else if (down_reg && count_reg == `TMR8_BOTTOM) begin
               down_reg  <= 1'b0;
               count_reg <= count_reg + 1'b1;
            end else if (down_reg) begin
               count_reg <= count_reg - 1'b1;
            end else begin
               count_reg <= count_reg + 1'b1;
            end
         end else if (at_top && !block_reg) begin
            down_reg  <= 1'b0;
            count_reg <= `TMR8_BOTTOM;   // CLEAR_ON_MATCH_MODE / fast clear; force never reaches here
         end else begin
            down_reg  <= 1'b0;
            count_reg <= count_reg + 1'b1;
         end
      end
   end

   // Suppress flag held until the next tick after a write
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         block_reg <= 1'b0;
      end else if (wr_count) begin
         block_reg <= 1'b1;
      end else if (tick) begin
         block_reg <= 1'b0;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Compare update point: TOP in fast PWM, TOP turning in phase correct
   assign upd_pt = tick && at_top && (phase_c ? !down_reg : 1'b1);

   // Buffered compare values; PWM modes load them at TOP
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cmp_a_buf_reg <= `TMR8_RST_BYTE;
         cmp_b_buf_reg <= `TMR8_RST_BYTE;
         cmp_a_reg     <= `TMR8_RST_BYTE;
         cmp_b_reg     <= `TMR8_RST_BYTE;
      end else begin
         if (wr_to(REQ, `TMR8_OFS_CMP_A)) begin
            cmp_a_buf_reg <= REQ.wdata;
         end
         if (wr_to(REQ, `TMR8_OFS_CMP_B)) begin
            cmp_b_buf_reg <= REQ.wdata;
         end
         if (!pwm) begin
            // Immediate update
            if (wr_to(REQ, `TMR8_OFS_CMP_A)) begin
               cmp_a_reg <= REQ.wdata;
            end
            if (wr_to(REQ, `TMR8_OFS_CMP_B)) begin
               cmp_b_reg <= REQ.wdata;
            end
         end else if (upd_pt) begin
            cmp_a_reg <= cmp_a_buf_reg;
            cmp_b_reg <= cmp_b_buf_reg;
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl_a_reg <= `TMR8_RST_BYTE;
         ctrl_b_reg <= 4'h0;
         mask_reg   <= 3'h0;
      end else begin
         if (wr_to(REQ, `TMR8_OFS_CTRL_A)) begin
            ctrl_a_reg <= REQ.wdata & 8'hf3;   // Bits 3:2 reserved
         end
         if (wr_to(REQ, `TMR8_OFS_CTRL_B)) begin
            ctrl_b_reg <= REQ.wdata[3:0];
         end
         if (wr_to(REQ, `TMR8_OFS_IRQ_MASK)) begin
            mask_reg <= REQ.wdata[2:0];
         end
      end
   end

   // Force strobes, never stored; ignored in PWM modes
   assign force_a = wr_to(REQ, `TMR8_OFS_CTRL_B) && REQ.wdata[`TMR8_B_FORCE_A] && !pwm;
   assign force_b = wr_to(REQ, `TMR8_OFS_CTRL_B) && REQ.wdata[`TMR8_B_FORCE_B] && !pwm;

////////////////////////////////////////////////////////////////////////////////
   // Flags: hardware set beats software or acknowledge clear
   always_comb begin
      flag_next = flag_reg;
      if (wr_to(REQ, `TMR8_OFS_IRQ_FLAGS)) begin
         flag_next = flag_next & ~REQ.wdata[2:0];
      end
      flag_next = flag_next & ~{IRQ_ACK.cmp_b, IRQ_ACK.cmp_a, IRQ_ACK.ovf};
      // Forced matches take no part here
      flag_next[`TMR8_F_CMP_B] = flag_next[`TMR8_F_CMP_B] | match_b;
      flag_next[`TMR8_F_CMP_A] = flag_next[`TMR8_F_CMP_A] | match_a;
      flag_next[`TMR8_F_OVF]   = flag_next[`TMR8_F_OVF] | ovf_ev;
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         flag_reg <= 3'h0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   // Request lines combine mask, global enable and flag
   assign IRQ_REQ.cmp_b = mask_reg[`TMR8_F_CMP_B] && GLOBAL_IRQ_EN && flag_reg[`TMR8_F_CMP_B];
   assign IRQ_REQ.cmp_a = mask_reg[`TMR8_F_CMP_A] && GLOBAL_IRQ_EN && flag_reg[`TMR8_F_CMP_A];
   assign IRQ_REQ.ovf   = mask_reg[`TMR8_F_OVF] && GLOBAL_IRQ_EN && flag_reg[`TMR8_F_OVF];

////////////////////////////////////////////////////////////////////////////////
   // Waveform outputs; only the non-PWM output modes are built here
   function automatic logic wave_next(input logic cur, input logic [1:0] om);
      unique case (om)
         2'h0: wave_next = cur;
         2'h1: wave_next = !cur;
         2'h2: wave_next = 1'b0;
         2'h3: wave_next = 1'b1;
      endcase
   endfunction

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wave_a_reg <= 1'b0;
         wave_b_reg <= 1'b0;
      end else begin
         if (force_a || (match_a && !pwm)) begin
            wave_a_reg <= wave_next(wave_a_reg, ctrl_a_reg[7:6]);
         end
         if (force_b || (match_b && !pwm)) begin
            wave_b_reg <= wave_next(wave_b_reg, ctrl_a_reg[5:4]);
         end
      end
   end

   assign WAVE_OUT_A = wave_a_reg;
   assign WAVE_OUT_B = wave_b_reg;
   assign WAVE_EN_A  = ctrl_a_reg[7:6] != 2'h0;
   assign WAVE_EN_B  = ctrl_a_reg[5:4] != 2'h0;

////////////////////////////////////////////////////////////////////////////////
   // Read data stands the cycle after the read strobe
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rdata_reg <= 8'h00;
      end else if (REQ.rd) begin
         unique case (REQ.addr)
            `TMR8_OFS_CTRL_A:    rdata_reg <= ctrl_a_reg;
            `TMR8_OFS_CTRL_B:    rdata_reg <= {4'h0, ctrl_b_reg};
            `TMR8_OFS_COUNT:     rdata_reg <= count_reg;
            `TMR8_OFS_CMP_A:     rdata_reg <= cmp_a_buf_reg;
            `TMR8_OFS_CMP_B:     rdata_reg <= cmp_b_buf_reg;
            `TMR8_OFS_IRQ_MASK:  rdata_reg <= {5'h00, mask_reg};
            `TMR8_OFS_IRQ_FLAGS: rdata_reg <= {5'h00, flag_reg};
            default:             rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign RDATA = rdata_reg;
endmodule
`default_nettype wire

/* File: hdl/tmr8_params.svh */
`ifndef TMR8_PARAMS_SVH
`define TMR8_PARAMS_SVH
// Register offsets on the plain register port (chosen map)
`define TMR8_OFS_CTRL_A    3'h0
`define TMR8_OFS_CTRL_B    3'h1
`define TMR8_OFS_COUNT     3'h2
`define TMR8_OFS_CMP_A     3'h3
`define TMR8_OFS_CMP_B     3'h4
`define TMR8_OFS_IRQ_MASK  3'h5
`define TMR8_OFS_IRQ_FLAGS 3'h6
// Control B fields
`define TMR8_B_FORCE_A     7
`define TMR8_B_FORCE_B     6
`define TMR8_B_MODE_HI     3
// Flag and mask fields
`define TMR8_F_CMP_B       2
`define TMR8_F_CMP_A       1
`define TMR8_F_OVF         0
// Counter landmarks and reset values
`define TMR8_MAX           8'hff
`define TMR8_BOTTOM        8'h00
`define TMR8_RST_BYTE      8'h00
// Prescaler taps
`define TMR8_DIV8          8
`define TMR8_DIV64         64
`define TMR8_DIV256        256
`define TMR8_DIV1024       1024
`endif

/* File: hdl/tmr8_pkg.sv */
package tmr8_pkg;
   // Waveform mode codes, high bit from control B, low bits from control A
   typedef enum logic [2:0] {
      TMR8_WM_NORMAL   = 3'h0,
      TMR8_WM_PC_FF    = 3'h1,
      TMR8_WM_CTC      = 3'h2,
      TMR8_WM_FAST_FF  = 3'h3,
      TMR8_WM_RSV4     = 3'h4,
      TMR8_WM_PC_OCA   = 3'h5,
      TMR8_WM_RSV6     = 3'h6,
      TMR8_WM_FAST_OCA = 3'h7
   } tmr8_wmode_t;

   // Register port request
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tmr8_req_t;

   // Interrupt request lines
   typedef struct packed {
      logic cmp_b;
      logic cmp_a;
      logic ovf;
   } tmr8_irq_t;
endpackage

/* File: verification/tmr8_core_test.sv */
`timescale 1ns/100ps
`default_nettype none
module tmr8_core_test import tmr8_pkg::*;;
   logic       clk;
   logic       arst_n;
   tmr8_req_t  req;
   logic [7:0] rdata;
   logic       gie;
   tmr8_irq_t  ack;
   tmr8_irq_t  irq;
   logic       pin;
   logic       wa;
   logic       wb;
   logic       ea;
   logic       eb;
   logic [7:0] v;
   int         n_errors;
   int         total_checks;
   int         divs [5] = '{1, 8, 64, 256, 1024};
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, device and CPU model
   always #4 clk = ~clk;
   tmr8_core u_tmr8_core (.CLK(clk), .ARST_N(arst_n), .REQ(req), .RDATA(rdata),
      .GLOBAL_IRQ_EN(gie), .IRQ_ACK(ack), .IRQ_REQ(irq), .EXT_COUNT_PIN(pin),
      .WAVE_OUT_A(wa), .WAVE_OUT_B(wb), .WAVE_EN_A(ea), .WAVE_EN_B(eb));
   tmr8_cpu_model u_tmr8_cpu_model (.clk(clk), .arst_n(arst_n), .irq_req(irq), .irq_ack(ack));
   ////////////////////////////////////////////////////////////////////////////////
   // Compare and verdict
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Bus cycles; an idle edge after each keeps strobes to one driver step
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [2:0] a);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      req <= '0;
      #1 v = rdata;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
      rd(a);
      check(v, exp);
   endtask
   // Count window, since the prescaler phase is free running
   task automatic rng(input logic [7:0] lo, input logic [7:0] hi);
      rd(3'h2);
      check({7'h00, (v >= lo && v <= hi)}, 8'h01);
   endtask
   task automatic run(input logic [7:0] sel, input int n);
      wr(3'h1, sel);
      repeat (n) @(posedge clk);
      wr(3'h1, 8'h00);
   endtask
   // Pins looked at once settled, away from the edge
   task automatic pins(input logic [7:0] exp, input logic en);
      @(posedge clk);
      #1 check(en ? {6'h00, ea, eb} : {6'h00, wa, wb}, exp);
      @(posedge clk);
   endtask
   // Counter load with read back in the next cycle
   task automatic ldrd(input logic [7:0] d);
      req <= '{3'h2, d, 1'b1, 1'b0};
      @(posedge clk);
      req <= '{3'h2, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      req <= '0;
      #1 check(rdata, d);
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      req = '0;
      gie = 1'b0;
      pin = 1'b0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      for (int a = 0; a < 8; a++) begin
         rdc(3'(a), 8'h00);
      end
      // Forced matches: set, clear, toggle, then ignored in a PWM mode
      wr(3'h0, 8'hd0);
      pins(8'h03, 1'b1);
      wr(3'h1, 8'hc0);
      pins(8'h03, 1'b0);
      rdc(3'h1, 8'h00);
      rdc(3'h6, 8'h00);
      wr(3'h0, 8'ha0);
      wr(3'h1, 8'hc0);
      pins(8'h00, 1'b0);
      wr(3'h0, 8'h50);
      wr(3'h1, 8'h80);
      pins(8'h02, 1'b0);
      wr(3'h0, 8'h51);
      wr(3'h1, 8'hc0);
      pins(8'h02, 1'b0);
      wr(3'h0, 8'h00);
      pins(8'h00, 1'b1);
      // Counter loads while it counts every clock
      wr(3'h1, 8'h01);
      ldrd(8'h00);
      ldrd(8'h7f);
      ldrd(8'hff);
      wr(3'h1, 8'h00);
      // Normal count through both matches and the wrap
      wr(3'h3, 8'hf2);
      wr(3'h4, 8'hf4);
      wr(3'h2, 8'hf0);
      wr(3'h6, 8'h07);
      run(8'h01, 30);
      rdc(3'h6, 8'h07);
      wr(3'h6, 8'h02);
      rdc(3'h6, 8'h05);
      // Only the unmasked source is served by the CPU model
      wr(3'h5, 8'hf9);
      rdc(3'h5, 8'h01);
      gie <= 1'b1;
      repeat (4) @(posedge clk);
      rdc(3'h6, 8'h04);
      wr(3'h5, 8'h04);
      repeat (4) @(posedge clk);
      rdc(3'h6, 8'h00);
      gie <= 1'b0;
      // Clear on compare A, then a forced match with count equal to A
      wr(3'h0, 8'h02);
      wr(3'h3, 8'h05);
      wr(3'h2, 8'h00);
      run(8'h01, 40);
      rng(8'h00, 8'h05);
      rdc(3'h6, 8'h02);
      wr(3'h2, 8'h05);
      wr(3'h6, 8'h07);
      wr(3'h1, 8'h80);
      rdc(3'h2, 8'h05);
      rdc(3'h6, 8'h00);
      // Fast PWM with compare A as TOP; A loaded while still immediate
      wr(3'h3, 8'h10);
      wr(3'h0, 8'h03);
      wr(3'h2, 8'h00);
      wr(3'h6, 8'h07);
      run(8'h09, 30);
      rng(8'h00, 8'h10);
      rdc(3'h6, 8'h03);
      // Phase correct with TOP 4: nine ticks go up, turn, hit BOTTOM, turn
      wr(3'h0, 8'h00);
      wr(3'h3, 8'h04);
      wr(3'h0, 8'h01);
      wr(3'h2, 8'h00);
      wr(3'h6, 8'h07);
      run(8'h09, 7);
      rdc(3'h2, 8'h01);
      rdc(3'h6, 8'h03);
      // Every prescaler tap gives ten ticks
      wr(3'h0, 8'h00);
      for (int i = 0; i < 5; i++) begin
         wr(3'h2, 8'h00);
         run(8'(i + 1), 10 * divs[i] - 2);
         rng(8'h09, 8'h0b);
      end
      // Pin edges, rising then falling
      for (int s = 7; s > 5; s--) begin
         wr(3'h2, 8'h00);
         wr(3'h1, 8'(s));
         repeat (3) begin
            pin <= 1'b1;
            repeat (3) @(posedge clk);
            pin <= 1'b0;
            repeat (3) @(posedge clk);
         end
         rdc(3'h2, 8'h03);
      end
      results();
   end
endmodule
`default_nettype wire

/* File: verification/tmr8_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tmr8_cpu_model import tmr8_pkg::*; (
   // Clock and reset
   input  wire logic      clk,
   input  wire logic      arst_n,
   // Interrupt handshake
   input  wire tmr8_irq_t irq_req,
   output tmr8_irq_t      irq_ack
);
   // Vector fetch acks each pending request; the idle cycle between acks
   // gives the cleared flag time to drop the request
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_ack <= '0;
      end else begin
         irq_ack <= irq_req & ~irq_ack;
      end
   end
endmodule
`default_nettype wire

/* File: verification/tmr8_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module tmr8_monitor import tmr8_pkg::*; (
   // Clock and reset
   input wire logic       CLK,
   input wire logic       ARST_N,
   // Register port and interrupt side
   input wire tmr8_req_t  REQ,
   input wire logic [7:0] RDATA,
   input wire logic       GLOBAL_IRQ_EN,
   input wire tmr8_irq_t  IRQ_REQ,
   // Pin enable
   input wire logic       WAVE_EN_A
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   ////////////////////////////////////////////////////////////////////////////////
   // Requests only pass with the global enable
   a_no_irq_gated:
   assert property (!GLOBAL_IRQ_EN |-> IRQ_REQ == 3'b000) else $error("request while gated");
   a_ovf_irq_gate:
   assert property (IRQ_REQ.ovf |-> GLOBAL_IRQ_EN) else $error("overflow request ungated");
   a_cmpa_irq_rise:
   assert property ($rose(IRQ_REQ.cmp_a) |-> GLOBAL_IRQ_EN) else $error("compare A ungated");
   a_cmpb_irq_rise:
   assert property ($rose(IRQ_REQ.cmp_b) |-> GLOBAL_IRQ_EN) else $error("compare B ungated");
   // Read data layouts
   a_ctlb_read_zeros:
   assert property (($past(REQ.rd) && $past(REQ.addr) == 3'h1) |-> RDATA[7:4] == 4'h0)
      else $error("control B force or spare bits read set");
   a_flag_read_zeros:
   assert property (($past(REQ.rd) && ($past(REQ.addr) inside {3'h5, 3'h6}))
      |-> RDATA[7:3] == 5'h00) else $error("mask or flag spare bits read set");
   // Output enable follows the output mode just written
   a_wave_en_a:
   assert property (($past(REQ.wr) && $past(REQ.addr) == 3'h0)
      |-> WAVE_EN_A == ($past(REQ.wdata[7:6]) != 2'b00)) else $error("enable A wrong");
   // A counter write wins over the same-cycle tick
   a_count_load:
   assert property ((REQ.wr && REQ.addr == 3'h2) ##1 (REQ.rd && REQ.addr == 3'h2)
      |=> RDATA == $past(REQ.wdata, 2)) else $error("counter load lost");
endmodule
bind tmr8_core tmr8_monitor u_tmr8_monitor (.CLK(CLK), .ARST_N(ARST_N), .REQ(REQ),
   .RDATA(RDATA), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .IRQ_REQ(IRQ_REQ), .WAVE_EN_A(WAVE_EN_A));
`default_nettype wire
